// ### core/rfc_bit_timer.sv
/*
  rfc_bit_timer: bit-period divider; emits one pulse per bit period.
  assumes a period value in pclk cycles, nonzero; zero is treated as one.
*/
module rfc_bit_timer
  import rfc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        restart,
  input  wire logic [15:0] period,
  // tick
  output logic             tick
);
  logic [15:0] cnt_r;
  wire         wrap = (cnt_r + 16'h0001 >= period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_r <= (restart || wrap) ? 16'h0000 : cnt_r + 16'h0001;
      tick  <= !restart && wrap;
    end
  end
endmodule : rfc_bit_timer

// ### core/rfc_pkg.sv
/*
  rfc_pkg: constants, register offsets, field positions and mode encodings
  for the receive-path frequency correction, temperature and timeout block.
  assumes a 20 MHz pclk and a 32-bit APB register bus.
*/
package rfc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_MODE       = 8'h00;  // operating_mode_reg
  localparam logic [7:0] ADDR_CORR_CTRL  = 8'h04;  // correction_control_reg
  localparam logic [7:0] ADDR_CORR_MODE  = 8'h08;  // correction_mode_reg
  localparam logic [7:0] ADDR_CORR_BW    = 8'h0C;  // correction_bandwidth_reg
  localparam logic [7:0] ADDR_LOW_OFS    = 8'h10;  // low_index_offset_reg
  localparam logic [7:0] ADDR_FERR       = 8'h14;  // freq_error_reg
  localparam logic [7:0] ADDR_CARRIER    = 8'h18;  // carrier frequency word
  localparam logic [7:0] ADDR_TEMP       = 8'h1C;  // temperature control/result
  localparam logic [7:0] ADDR_TIMEOUT    = 8'h20;  // timeout values
  localparam logic [7:0] ADDR_BITRATE    = 8'h24;  // bit period in pclk cycles
  localparam logic [7:0] ADDR_STATUS     = 8'h28;  // status flags
  localparam logic [7:0] ADDR_RX_BW      = 8'h2C;  // normal receive bandwidth

  // operating_mode_reg fields
  localparam int MODE_LSB          = 2;
  localparam int LISTEN_BIT        = 6;
  localparam int SEQ_DIS_BIT       = 7;
  // correction_control_reg fields
  localparam int CORR_START_BIT    = 0;
  localparam int CORR_CLEAR_BIT    = 1;
  localparam int AUTO_CORR_BIT     = 2;
  localparam int AUTO_CLEAR_BIT    = 3;
  localparam int FERR_START_BIT    = 5;
  localparam int CORR_DONE_BIT     = 4;
  localparam int FERR_DONE_BIT     = 6;
  // correction_mode_reg field
  localparam int LOW_INDEX_BIT     = 5;
  // temperature register fields
  localparam int TEMP_START_BIT    = 3;
  localparam int TEMP_RUN_BIT      = 2;
  localparam int TEMP_RES_LSB      = 8;
  // status fields
  localparam int ST_TIMEOUT_BIT    = 0;
  localparam int ST_THRESH_BIT     = 1;

  // reset values
  localparam logic [7:0]  MODE_RST     = 8'h04;
  localparam logic [7:0]  CORR_CTRL_RST= 8'h00;
  localparam logic [7:0]  CORR_BW_RST  = 8'h8B;
  localparam logic [7:0]  RX_BW_RST    = 8'h55;
  localparam logic [23:0] CARRIER_RST  = 24'hE4C000;
  localparam logic [15:0] BITRATE_RST  = 16'h0208;

  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STBY  = 3'h1,
    MODE_FS    = 3'h2,
    MODE_TX    = 3'h3,
    MODE_RX    = 3'h4
  } rfc_mode_e;

  // block enables: listen, rx, tx, synth, xo/regulator
  localparam int EN_W = 5;
  localparam logic [EN_W-1:0] EN_NONE  = 5'h00;
  localparam logic [EN_W-1:0] EN_STBY  = 5'h01;
  localparam logic [EN_W-1:0] EN_FS    = 5'h03;
  localparam logic [EN_W-1:0] EN_TX    = 5'h07;
  localparam logic [EN_W-1:0] EN_RX    = 5'h0B;
  localparam logic [EN_W-1:0] EN_LISTEN= 5'h11;

  // timing
  localparam int  CLK_HZ         = 20_000_000;
  localparam int  FERR_BITS      = 4;
  localparam int  TIMEOUT_STEP   = 8;
  localparam int  LOW_STEP_HZ    = 488;
  localparam int  TEMP_MAX_US    = 100;
  localparam int  TEMP_MEAS_CYC  = (TEMP_MAX_US * (CLK_HZ / 1_000_000)) / 2;
  localparam int  SEQ_STEP_CYC   = 16;

endpackage : rfc_pkg

// ### core/rfc_tick_if.sv
/*
  rfc_tick_if: bit-period tick shared between the top and the timeout timer.
  assumes one clock domain.
*/
interface rfc_tick_if;
  logic       bit_tick;
  logic       rx_enter;
  logic       thresh;
  logic [7:0] rx_start_timeout;
  logic [7:0] threshold_timeout;
  logic       timeout_evt;
  modport src (output bit_tick, rx_enter, thresh, rx_start_timeout, threshold_timeout,
               input timeout_evt);
  modport dst (input bit_tick, rx_enter, thresh, rx_start_timeout, threshold_timeout,
               output timeout_evt);
endinterface : rfc_tick_if

// ### core/rfc_timeout.sv
/*
  rfc_timeout: the two receive timeouts on one shared counter, counted in bit periods.
  assumes rx_enter pulses once on each entry into receive mode.
*/
module rfc_timeout
  import rfc_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // link to top
  rfc_tick_if.dst   t
);
  logic [11:0] cnt_r;
  logic        seen_r;
  logic        armed_r;
  wire  [11:0] lim_start  = {1'b0, t.rx_start_timeout, 3'h0};
  wire  [11:0] lim_thresh = {1'b0, t.threshold_timeout, 3'h0};
  wire  [11:0] lim        = seen_r ? lim_thresh : lim_start;
  wire         hit        = armed_r && t.bit_tick && (lim != 12'h000)
                            && (cnt_r + 12'h001 >= lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 12'h000;
      seen_r <= 1'b0;
      armed_r <= 1'b0;
      t.timeout_evt <= 1'b0;
    end else begin
      t.timeout_evt <= hit;
      if (t.rx_enter) begin
        cnt_r   <= 12'h000;
        seen_r  <= 1'b0;
        armed_r <= 1'b1;
      end else if (t.thresh && !seen_r) begin
        cnt_r  <= 12'h000;
        seen_r <= 1'b1;
      end else if (hit) begin
        armed_r <= 1'b0;
      end else if (t.bit_tick && armed_r) begin
        cnt_r <= cnt_r + 12'h001;
      end
    end
  end
endmodule : rfc_timeout

// ### core/rfc_top.sv
/*
  rfc_top: mode decoder and wake-up sequencer, frequency error measurement,
  automatic frequency correction, temperature measurement and rx timeout,
  all behind an APB slave.
  assumes the demodulator supplies a signed per-bit phase error sample and
  the signal threshold flag on pclk; temperature sample arrives as a level.
*/
module rfc_top
  import rfc_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // demodulator side
  input  wire logic [15:0] error_sample,
  input  wire logic        signal_threshold_flag,
  input  wire logic [7:0]  temp_sensor,
  // analog controls
  output logic [EN_W-1:0]  block_enable,
  output logic [23:0]      carrier_freq,
  output logic [7:0]       channel_bw,
  output logic             rx_timeout
);

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_MEAS = 4'b0010,
    C_APPLY = 4'b0100,
    C_DONE = 4'b1000
  } rfc_corr_e;

  // register state
  logic [7:0]  mode_r, corr_ctrl_r, corr_mode_r, corr_bw_r, rx_bw_r, low_ofs_r;
  logic [7:0]  to_start_r, to_thresh_r, temp_res_r;
  logic [15:0] ferr_r, bitrate_r, corr_val_r;
  logic [23:0] carrier_r;
  logic        temp_run_r, ferr_done_r, corr_done_r, timeout_st_r;
  logic [11:0] temp_cnt_r;
  logic [2:0]  cur_mode_r;
  logic [4:0]  seq_cnt_r;
  rfc_corr_e   cstate_r;
  logic        corr_phase_r, meas_only_r;
  logic [2:0]  bits_r;
  logic [19:0] acc_r;
  logic        rx_prev_r;

  // apb decode
  wire       wr_en  = psel && penable && pwrite;
  wire       rd_acc = psel && !penable && !pwrite;
  wire       mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_RX_BW);
  wire       wr_mode = wr_en && paddr == ADDR_MODE;
  wire       wr_cc   = wr_en && paddr == ADDR_CORR_CTRL;
  wire       wr_temp = wr_en && paddr == ADDR_TEMP;

  // mode decode
  wire [2:0] req_mode   = mode_r[MODE_LSB+2:MODE_LSB];
  wire       listen     = mode_r[LISTEN_BIT];
  wire       seq_dis    = mode_r[SEQ_DIS_BIT];
  wire       in_rx      = !listen && cur_mode_r == MODE_RX;
  wire       rx_rise    = in_rx && !rx_prev_r;
  wire [2:0] seq_next   = (cur_mode_r < req_mode) ?
                          ((cur_mode_r == MODE_FS) ? req_mode : cur_mode_r + 3'h1) :
                          req_mode;
  logic [EN_W-1:0] en_dec;
  always_comb begin
    case (cur_mode_r)
      MODE_SLEEP: en_dec = EN_NONE;
      MODE_STBY:  en_dec = EN_STBY;
      MODE_FS:    en_dec = EN_FS;
      MODE_TX:    en_dec = EN_TX;
      MODE_RX:    en_dec = EN_RX;
      default:    en_dec = EN_NONE;
    endcase
  end
  wire [EN_W-1:0] en_final = listen ? EN_LISTEN : en_dec;

  // correction triggers
  wire auto_on   = corr_ctrl_r[AUTO_CORR_BIT];
  wire auto_clr  = corr_ctrl_r[AUTO_CLEAR_BIT];
  wire sw_start  = wr_cc && pwdata[CORR_START_BIT] && !auto_on;
  wire ferr_go   = wr_cc && pwdata[FERR_START_BIT];
  wire auto_go   = auto_on && rx_rise;
  wire launch    = cstate_r == C_IDLE && (sw_start || auto_go || ferr_go);

  // bit ticks, shared with the timeout counter
  logic bit_tick;
  rfc_tick_if tk ();
  rfc_bit_timer u_bt (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (rx_rise),
    .period  (bitrate_r),
    .tick    (bit_tick)
  );
  assign tk.bit_tick          = bit_tick;
  assign tk.rx_enter          = rx_rise;
  assign tk.thresh            = signal_threshold_flag;
  assign tk.rx_start_timeout  = to_start_r;
  assign tk.threshold_timeout = to_thresh_r;
  rfc_timeout u_to (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (tk)
  );

  // averaged error over four bit periods; divide by four keeps the sign
  wire [19:0] acc_nxt  = acc_r + {{4{error_sample[15]}}, error_sample};
  wire [15:0] ferr_nxt = acc_nxt[17:2];
  // offset in synthesizer steps: offset * 488 Hz / ~61 Hz step = offset * 8
  wire [15:0] low_hz_steps = {5'h00, low_ofs_r, 3'h0};
  wire        low_on   = corr_mode_r[LOW_INDEX_BIT];
  wire [15:0] corr_nxt = low_on ? ferr_r + low_hz_steps : ferr_r;
  wire [23:0] base_car = (auto_on && auto_clr) ? carrier_r + {{8{corr_val_r[15]}}, corr_val_r}
                                               : carrier_r;

  // temperature trigger only from standby or synthesizer
  wire temp_ok   = !listen && (cur_mode_r == MODE_STBY || cur_mode_r == MODE_FS);
  wire temp_go   = wr_temp && pwdata[TEMP_START_BIT] && temp_ok && !temp_run_r;
  wire temp_end  = temp_run_r && temp_cnt_r == 12'(TEMP_MEAS_CYC - 1);

  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      ADDR_MODE:      rd_mux = {24'h0, mode_r};
      ADDR_CORR_CTRL: rd_mux = {25'h0, ferr_done_r, 1'b0, corr_done_r, corr_ctrl_r[3:2], 2'b00};
      ADDR_CORR_MODE: rd_mux = {24'h0, corr_mode_r};
      ADDR_CORR_BW:   rd_mux = {24'h0, corr_bw_r};
      ADDR_LOW_OFS:   rd_mux = {24'h0, low_ofs_r};
      ADDR_FERR:      rd_mux = {corr_val_r, ferr_r};
      ADDR_CARRIER:   rd_mux = {8'h0, carrier_r};
      ADDR_TEMP:      rd_mux = {16'h0, temp_res_r, 5'h0, temp_run_r, 2'b00};
      ADDR_TIMEOUT:   rd_mux = {16'h0, to_thresh_r, to_start_r};
      ADDR_BITRATE:   rd_mux = {16'h0, bitrate_r};
      ADDR_STATUS:    rd_mux = {29'h0, cur_mode_r == req_mode, signal_threshold_flag,
                                timeout_st_r};
      ADDR_RX_BW:     rd_mux = {24'h0, rx_bw_r};
      default:        rd_mux = 32'h0;
    endcase
  end

  // apb slave: one wait-free access phase, read data registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_acc) prdata <= mapped ? rd_mux : 32'h0;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r      <= MODE_RST;
      corr_ctrl_r <= CORR_CTRL_RST;
      corr_mode_r <= 8'h00;
      corr_bw_r   <= CORR_BW_RST;
      rx_bw_r     <= RX_BW_RST;
      low_ofs_r   <= 8'h00;
      to_start_r  <= 8'h00;
      to_thresh_r <= 8'h00;
      bitrate_r   <= BITRATE_RST;
    end else if (wr_en && mapped) begin
      case (paddr)
        ADDR_MODE:      mode_r      <= pwdata[7:0];
        ADDR_CORR_CTRL: corr_ctrl_r <= {4'h0, pwdata[3:2], 2'b00};
        ADDR_CORR_MODE: corr_mode_r <= pwdata[7:0];
        ADDR_CORR_BW:   corr_bw_r   <= pwdata[7:0];
        ADDR_LOW_OFS:   low_ofs_r   <= pwdata[7:0];
        ADDR_TIMEOUT: begin
          to_start_r  <= pwdata[7:0];
          to_thresh_r <= pwdata[15:8];
        end
        ADDR_BITRATE:   bitrate_r   <= pwdata[15:0];
        ADDR_RX_BW:     rx_bw_r     <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // mode sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_mode_r <= MODE_STBY;
      seq_cnt_r  <= 5'h00;
      rx_prev_r  <= 1'b0;
    end else begin
      rx_prev_r <= in_rx;
      if (seq_dis) begin
        cur_mode_r <= req_mode;
        seq_cnt_r  <= 5'h00;
      end else if (cur_mode_r != req_mode) begin
        seq_cnt_r <= seq_cnt_r + 5'h01;
        if (seq_cnt_r == 5'(SEQ_STEP_CYC - 1)) begin
          cur_mode_r <= seq_next;
          seq_cnt_r  <= 5'h00;
        end
      end
    end
  end

  // correction engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cstate_r     <= C_IDLE;
      corr_phase_r <= 1'b0;
      meas_only_r  <= 1'b0;
      bits_r       <= 3'h0;
      acc_r        <= 20'h0;
      ferr_r       <= 16'h0;
      corr_val_r   <= 16'h0;
      carrier_r    <= CARRIER_RST;
      ferr_done_r  <= 1'b0;
      corr_done_r  <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_CARRIER) carrier_r <= pwdata[23:0];
      case (cstate_r)
        C_IDLE: begin
          if (launch) begin
            cstate_r     <= C_MEAS;
            corr_phase_r <= !(ferr_go && !sw_start && !auto_go);
            meas_only_r  <= ferr_go && !sw_start && !auto_go;
            bits_r       <= 3'h0;
            acc_r        <= 20'h0;
            if (auto_go && auto_clr) begin
              carrier_r  <= base_car;
              corr_val_r <= 16'h0;
            end
          end
        end
        C_MEAS: begin
          if (bit_tick) begin
            acc_r  <= acc_nxt;
            bits_r <= bits_r + 3'h1;
            if (bits_r == 3'(FERR_BITS - 1)) begin
              ferr_r   <= ferr_nxt;
              cstate_r <= meas_only_r ? C_DONE : C_APPLY;
            end
          end
        end
        C_APPLY: begin
          corr_val_r <= corr_nxt;
          carrier_r  <= carrier_r - {{8{corr_nxt[15]}}, corr_nxt};
          cstate_r   <= C_DONE;
        end
        C_DONE: begin
          corr_phase_r <= 1'b0;
          cstate_r     <= C_IDLE;
        end
        default: cstate_r <= C_IDLE;
      endcase
      // set in C_DONE wins over the clear on launch
      if (cstate_r == C_DONE) begin
        ferr_done_r <= 1'b1;
        corr_done_r <= !meas_only_r || corr_done_r;
      end else if (launch) begin
        ferr_done_r <= 1'b0;
        corr_done_r <= (ferr_go && !sw_start && !auto_go) ? corr_done_r : 1'b0;
      end
    end
  end

  // temperature measurement and timeout status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_run_r   <= 1'b0;
      temp_cnt_r   <= 12'h000;
      temp_res_r   <= 8'h00;
      timeout_st_r <= 1'b0;
    end else begin
      if (temp_go) begin
        temp_run_r <= 1'b1;
        temp_cnt_r <= 12'h000;
      end else if (temp_end) begin
        temp_run_r <= 1'b0;
        temp_res_r <= ~temp_sensor;
      end else if (temp_run_r) begin
        temp_cnt_r <= temp_cnt_r + 12'h001;
      end
      if (tk.timeout_evt) timeout_st_r <= 1'b1;
      else if (wr_en && paddr == ADDR_STATUS && pwdata[ST_TIMEOUT_BIT]) timeout_st_r <= 1'b0;
    end
  end

  // outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_enable <= EN_NONE;
      carrier_freq <= CARRIER_RST;
      channel_bw   <= RX_BW_RST;
      rx_timeout   <= 1'b0;
    end else begin
      block_enable <= en_final;
      carrier_freq <= carrier_r;
      channel_bw   <= corr_phase_r ? corr_bw_r : rx_bw_r;
      rx_timeout   <= tk.timeout_evt;
    end
  end
endmodule : rfc_top

// ### testbench/rfc_chk.sv
/*
  rfc_chk: port-level assertions for rfc_top.
  assumes it is bound to rfc_top; one clock, asynchronous active-low reset.
*/
module rfc_chk
  import rfc_pkg::*;
(
  // apb
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // demodulator side
  input wire logic [15:0]     error_sample,
  input wire logic            signal_threshold_flag,
  input wire logic [7:0]      temp_sensor,
  // analog controls
  input wire logic [EN_W-1:0] block_enable,
  input wire logic [23:0]     carrier_freq,
  input wire logic [7:0]      channel_bw,
  input wire logic            rx_timeout
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // only direct writes: sequenced mode changes take a variable number of steps
  wire mode_wr;
  assign mode_wr = psel && penable && pwrite && paddr == ADDR_MODE && pwdata[SEQ_DIS_BIT];

  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_read: assert property (psel && penable && !pwrite && paddr > ADDR_RX_BW
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  a_sleep_empty: assert property (!block_enable[0] |-> block_enable == EN_NONE)
    else $error("block enabled without regulator");
  a_rx_tx_apart: assert property (!(block_enable[2] && block_enable[3]))
    else $error("rx and tx enabled together");
  a_listen_alone: assert property (block_enable[4] |-> block_enable == EN_LISTEN)
    else $error("listen mixed with other blocks");
  a_direct_rx: assert property (mode_wr && !pwdata[LISTEN_BIT] && pwdata[4:2] == 3'h4
    |-> ##[1:3] block_enable == EN_RX) else $error("direct rx entry missing");
  a_direct_listen: assert property (mode_wr && pwdata[LISTEN_BIT]
    |-> ##[1:3] block_enable == EN_LISTEN) else $error("listen entry missing");
  a_timeout_pulse: assert property (rx_timeout |=> !rx_timeout)
    else $error("timeout longer than one cycle");
  a_rx_entry_quiet: assert property ($rose(block_enable[3]) |-> !rx_timeout [*4])
    else $error("timeout right after rx entry");

  c_timeout: cover property (rx_timeout);
  c_refused: cover property (pslverr);
  c_listen: cover property (block_enable == EN_LISTEN);
endmodule : rfc_chk

// ### testbench/rfc_top_bench.sv
/*
  rfc_top_bench: directed self-checking bench for rfc_top, checker bound.
  assumes a 20 MHz pclk; the bench drives apb and demodulator inputs itself.
*/
bind rfc_top rfc_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .error_sample(error_sample), .signal_threshold_flag(signal_threshold_flag),
  .temp_sensor(temp_sensor), .block_enable(block_enable), .carrier_freq(carrier_freq),
  .channel_bw(channel_bw), .rx_timeout(rx_timeout)
);

module rfc_top_bench
  import rfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            pclk = 1'b0;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [15:0]     error_sample;
  logic            signal_threshold_flag;
  logic [7:0]      temp_sensor;
  logic [EN_W-1:0] block_enable;
  logic [23:0]     carrier_freq;
  logic [7:0]      channel_bw;
  logic            rx_timeout;
  logic [31:0]     rd;
  logic            serr;
  int              tests_run = 0;
  int              miscompares = 0;

  rfc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .error_sample(error_sample), .signal_threshold_flag(signal_threshold_flag),
    .temp_sensor(temp_sensor), .block_enable(block_enable), .carrier_freq(carrier_freq),
    .channel_bw(channel_bw), .rx_timeout(rx_timeout)
  );

  always #25 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang();
    miscompares++;
    tally_and_finish();
  endtask : hang

  // request stands until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) hang();
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int n = 0; n < 400; n++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === v) return;
    end
    hang();
  endtask : poll

  task automatic wait_change(input int lim);
    logic [23:0] old;
    old = carrier_freq;
    for (int n = 0; n < lim && carrier_freq === old; n++) @(negedge pclk);
  endtask : wait_change

  task automatic count_to(output int n);
    for (n = 0; n < 300 && rx_timeout !== 1'b1; n++) @(negedge pclk);
  endtask : count_to

  task automatic t_reset();
    repeat (2) @(negedge pclk);
    chk(32'(block_enable), 32'(EN_STBY));
    chk(32'(carrier_freq), 32'(CARRIER_RST));
    chk(32'(channel_bw), 32'(RX_BW_RST));
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rd, 32'(MODE_RST));
    apb(1'b0, ADDR_CORR_BW, 32'h0);
    chk(rd, 32'(CORR_BW_RST));
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(serr), 32'h1);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_modes();
    logic [EN_W-1:0] e [5] = '{EN_NONE, EN_STBY, EN_FS, EN_TX, EN_RX};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_MODE, 32'h80 | (i << 2));
      repeat (3) @(negedge pclk);
      chk(32'(block_enable), 32'(e[i]));
    end
    apb(1'b1, ADDR_MODE, 32'h84);
    apb(1'b1, ADDR_MODE, 32'hC4);
    repeat (3) @(negedge pclk);
    chk(32'(block_enable), 32'(EN_LISTEN));
    apb(1'b1, ADDR_MODE, 32'h80);
    apb(1'b1, ADDR_MODE, 32'h0C);
    repeat (3) @(negedge pclk);
    chk(32'(block_enable === EN_TX), 32'h0);
    for (int n = 0; n < 100 && block_enable !== EN_TX; n++) @(negedge pclk);
    chk(32'(block_enable), 32'(EN_TX));
    $display("mode test done");
  endtask : t_modes

  task automatic t_corr();
    error_sample <= 16'hFFF0;
    apb(1'b1, ADDR_MODE, 32'h90);
    apb(1'b1, ADDR_CORR_CTRL, 32'h20);
    apb(1'b0, ADDR_CORR_CTRL, 32'h0);
    chk(32'(rd[FERR_DONE_BIT]), 32'h0);
    poll(ADDR_CORR_CTRL, FERR_DONE_BIT, 1'b1);
    apb(1'b0, ADDR_FERR, 32'h0);
    chk(32'(rd[15:0]), 32'hFFF0);
    chk(32'(carrier_freq), 32'(CARRIER_RST));
    apb(1'b1, ADDR_CORR_CTRL, 32'h1);
    // phase flag lands at the write edge, the bandwidth output one edge later
    repeat (2) @(negedge pclk);
    chk(32'(channel_bw), 32'(CORR_BW_RST));
    wait_change(200);
    chk(32'(carrier_freq), 32'hE4C010);
    apb(1'b1, ADDR_CORR_MODE, 32'h20);
    apb(1'b1, ADDR_LOW_OFS, 32'h3);
    apb(1'b1, ADDR_CORR_CTRL, 32'h1);
    wait_change(200);
    chk(32'(carrier_freq), 32'hE4C008);
    apb(1'b1, ADDR_CORR_MODE, 32'h0);
    chk(32'(channel_bw), 32'(RX_BW_RST));
    $display("correction test done");
  endtask : t_corr

  task automatic t_auto();
    apb(1'b1, ADDR_MODE, 32'h84);
    apb(1'b1, ADDR_CARRIER, 32'hE4C000);
    apb(1'b1, ADDR_CORR_CTRL, 32'h4);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) apb(1'b1, ADDR_CORR_CTRL, 32'hC);
      apb(1'b1, ADDR_MODE, 32'h84);
      apb(1'b1, ADDR_MODE, 32'h90);
      // the cleared pass may move the carrier twice, so it waits the full span
      if (i < 2) wait_change(200);
      else repeat (60) @(negedge pclk);
      chk(32'(carrier_freq), (i == 0) ? 32'hE4C010 : 32'hE4C020);
    end
    apb(1'b1, ADDR_CORR_CTRL, 32'h0);
    $display("auto correction test done");
  endtask : t_auto

  task automatic t_temp();
    time t0;
    apb(1'b1, ADDR_MODE, 32'h84);
    temp_sensor <= 8'h19;
    t0 = $time;
    apb(1'b1, ADDR_TEMP, 32'h8);
    apb(1'b0, ADDR_TEMP, 32'h0);
    chk(32'(rd[TEMP_RUN_BIT]), 32'h1);
    poll(ADDR_TEMP, TEMP_RUN_BIT, 1'b0);
    chk(32'($time - t0 <= 100_000), 32'h1);
    chk(32'(rd[15:8]), 32'hE6);
    apb(1'b1, ADDR_MODE, 32'h90);
    apb(1'b1, ADDR_TEMP, 32'h8);
    apb(1'b0, ADDR_TEMP, 32'h0);
    chk(32'(rd[TEMP_RUN_BIT]), 32'h0);
    $display("temperature test done");
  endtask : t_temp

  task automatic t_timeout();
    int n;
    apb(1'b1, ADDR_MODE, 32'h84);
    apb(1'b1, ADDR_TIMEOUT, 32'h0201);
    apb(1'b1, ADDR_MODE, 32'h90);
    count_to(n);
    chk(32'(n >= 24 && n <= 40), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[ST_TIMEOUT_BIT]), 32'h1);
    apb(1'b1, ADDR_MODE, 32'h84);
    apb(1'b1, ADDR_MODE, 32'h90);
    repeat (8) @(posedge pclk);
    signal_threshold_flag <= 1'b1;
    count_to(n);
    chk(32'(n >= 56 && n <= 72), 32'h1);
    signal_threshold_flag <= 1'b0;
    $display("timeout test done");
  endtask : t_timeout

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_sample = 16'h0000;
    signal_threshold_flag = 1'b0;
    temp_sensor = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    apb(1'b1, ADDR_BITRATE, 32'h4);
    t_modes();
    t_corr();
    t_auto();
    t_temp();
    t_timeout();
    tally_and_finish();
  end
endmodule : rfc_top_bench
